// ===== touch_boot_device.sv
// Touch controller end: two-wire slave with normal and bootloader modes.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "touch_boot_params.svh"
module touch_boot_device
   import touch_boot_pkg::*;
#(
   parameter int BOOT_WAIT = `BOOT_WAIT
) (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   i2c_link_if.dev         link,
   input  wire logic [7:0] flash_lock_i,
   input  wire logic       ee_fail_i,
   output logic            boot_mode_o,
   output logic            jump_allowed_o,
   output logic            int_o,
   output logic            flash_page_wr_o,
   output logic            flash_final_o,
   output logic            ee_page_wr_o
);
   localparam int WW = $clog2(BOOT_WAIT + 1);

   // ========================================================
   // Functions
   // One byte of the frame CRC, most significant bit first.
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0]  d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ `CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction : crc_byte

   // Byte returned at a given position of a read transaction.
   function automatic logic [7:0] rd_byte(input logic [7:0] idx,
                                          input logic       boot,
                                          input logic [7:0] stat,
                                          input logic [7:0] lock,
                                          input logic [7:0] spec);
      logic [7:0] b;
      b = 8'h00;
      if (!boot) begin
         b = (idx == 8'h00) ? spec : 8'h00;
      end else begin
         case (idx)
            8'h00:   b = stat;
            8'h01:   b = lock;
            8'h02:   b = `BOOT_VERSION;
            8'h03:   b = `KEY_LABEL; // arbitrary label value
            default: b = 8'h00;
         endcase
      end
      return b;
   endfunction : rd_byte

   // ========================================================
   // Line synchronisers and bus conditions
   logic [1:0]   scl_sync_r;
   logic [1:0]   sda_sync_r;
   logic         scl_d_r;
   logic         sda_d_r;
   logic         scl_s;
   logic         sda_s;
   logic         start_w;
   logic         stop_w;
   logic         rise_w;
   logic         fall_w;
   slave_state_t st_r;
   exec_state_t  ex_r;
   logic [3:0]   bit_r;
   logic [7:0]   sh_r;
   logic         rw_r;
   logic         mack_r;
   logic         sda_oe_r;
   logic [7:0]   wcnt_r;
   logic [7:0]   len_r;
   logic [7:0]   rd_idx_r;
   logic [7:0]   mem [0:`FRAME_LEN-1];
   logic [7:0]   idx_r;
   logic [15:0]  crc_r;
   logic [6:0]   cnt_r;
   logic         err_r;
   logic         open_r;
   logic         busy_r;
   logic         user_req_r;
   logic [7:0]   spec_r;
   logic         held_r;
   logic [WW-1:0] wait_r;
   logic [6:0]   addr_w;
   logic [7:0]   stat_w;
   logic [7:0]   tx_w;
   logic         lock_ok_w;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], link.scl};
         sda_sync_r <= {sda_sync_r[0], link.sda};
         scl_d_r    <= scl_sync_r[1];
         sda_d_r    <= sda_sync_r[1];
      end
   end

   // Start and stop are data edges while the clock stays high.
   assign scl_s     = scl_sync_r[1];
   assign sda_s     = sda_sync_r[1];
   assign start_w   = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_w    = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign rise_w    = scl_s & ~scl_d_r;
   assign fall_w    = ~scl_s & scl_d_r;
   assign addr_w    = boot_mode_o ? `ADDR_BOOT : `ADDR_NORMAL;
   assign stat_w    = {err_r, cnt_r};
   assign tx_w      = rd_byte(rd_idx_r, boot_mode_o, stat_w, flash_lock_i,
                              spec_r);
   assign lock_ok_w = (flash_lock_i == `LOCK_OPEN);
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = sda_oe_r;

   // ========================================================
   // Slave bit engine
   // A start is not taken while a frame runs, so nothing is acked.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r     <= S_IDLE;
         bit_r    <= 4'h0;
         sh_r     <= 8'h00;
         rw_r     <= 1'b0;
         mack_r   <= 1'b0;
         sda_oe_r <= 1'b0;
         wcnt_r   <= 8'h00;
         rd_idx_r <= 8'h00;
      end else if (start_w) begin
         st_r     <= busy_r ? S_IDLE : S_ADDR;
         bit_r    <= 4'h0;
         sda_oe_r <= 1'b0;
         wcnt_r   <= 8'h00;
      end else if (stop_w) begin
         st_r     <= S_IDLE;
         sda_oe_r <= 1'b0;
         wcnt_r   <= 8'h00;
      end else begin
         case (st_r)
            S_ADDR, S_WBYTE: begin
               if (rise_w) begin
                  sh_r  <= {sh_r[6:0], sda_s};
                  bit_r <= bit_r + 4'h1;
               end else if (fall_w && bit_r == 4'h8) begin
                  if (st_r == S_WBYTE) begin
                     st_r     <= S_ACK_W;
                     sda_oe_r <= 1'b1;
                     if (wcnt_r != 8'hff) begin
                        wcnt_r <= wcnt_r + 8'h01;
                     end
                  end else if (sh_r[7:1] == addr_w) begin
                     st_r     <= S_ACK_A;
                     rw_r     <= sh_r[0];
                     sda_oe_r <= 1'b1;
                     rd_idx_r <= 8'h00;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_ACK_A: begin
               if (fall_w) begin
                  bit_r <= 4'h0;
                  if (rw_r) begin
                     st_r     <= S_RBYTE;
                     sh_r     <= tx_w;
                     sda_oe_r <= ~tx_w[7];
                     rd_idx_r <= rd_idx_r + 8'h01;
                  end else begin
                     st_r     <= S_WBYTE;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            S_ACK_W: begin
               if (fall_w) begin
                  st_r     <= S_WBYTE;
                  bit_r    <= 4'h0;
                  sda_oe_r <= 1'b0;
               end
            end
            S_RBYTE: begin
               if (fall_w) begin
                  if (bit_r == 4'h7) begin
                     st_r     <= S_RACK;
                     sda_oe_r <= 1'b0;
                  end else begin
                     sh_r     <= {sh_r[6:0], 1'b0};
                     sda_oe_r <= ~sh_r[6];
                     bit_r    <= bit_r + 4'h1;
                  end
               end
            end
            S_RACK: begin
               if (rise_w) begin
                  mack_r <= ~sda_s;
               end else if (fall_w) begin
                  if (mack_r) begin
                     st_r     <= S_RBYTE;
                     bit_r    <= 4'h0;
                     sh_r     <= tx_w;
                     sda_oe_r <= ~tx_w[7];
                     rd_idx_r <= rd_idx_r + 8'h01;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Received write bytes land in the frame store.
   always_ff @(posedge ref_clk_i) begin
      if (st_r == S_WBYTE && fall_w && bit_r == 4'h8 &&
          wcnt_r < `FRAME_LEN) begin
         mem[wcnt_r] <= sh_r;
      end
   end

   // ========================================================
   // Command execution after the stop condition
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ex_r            <= EX_IDLE;
         busy_r          <= 1'b0;
         idx_r           <= 8'h00;
         crc_r           <= 16'h0000;
         cnt_r           <= 7'h00;
         err_r           <= 1'b0;
         open_r          <= 1'b0;
         len_r           <= 8'h00;
         user_req_r      <= 1'b0;
         spec_r          <= 8'h00;
         flash_page_wr_o <= 1'b0;
         flash_final_o   <= 1'b0;
         ee_page_wr_o    <= 1'b0;
      end else begin
         user_req_r      <= 1'b0;
         flash_page_wr_o <= 1'b0;
         flash_final_o   <= 1'b0;
         ee_page_wr_o    <= 1'b0;
         if (spec_r == `SPEC_OP_BOOT) begin
            spec_r <= 8'h00;
         end
         case (ex_r)
            EX_IDLE: begin
               if (stop_w && wcnt_r != 8'h00) begin
                  len_r <= wcnt_r;
                  if (!boot_mode_o) begin
                     if (wcnt_r >= 8'h02 && mem[0] == `SPEC_OP_IDX) begin
                        spec_r <= mem[1];
                     end
                  end else begin
                     case (mem[0])
                        `OP_INIT: begin
                           open_r <= 1'b1;
                           cnt_r  <= 7'h00;
                           err_r  <= 1'b0;
                        end
                        `OP_USER: user_req_r <= lock_ok_w;
                        `OP_FRAME: begin
                           if (open_r) begin
                              ex_r   <= EX_CRC;
                              busy_r <= 1'b1;
                              idx_r  <= 8'h00;
                              crc_r  <= 16'h0000;
                           end
                        end
                        `OP_EE_PAGE: begin
                           ee_page_wr_o <= 1'b1;
                           if (ee_fail_i || wcnt_r < 8'h02) begin
                              err_r <= 1'b1;
                           end
                        end
                        default: ;
                     endcase
                  end
               end
            end
            EX_CRC: begin
               crc_r <= crc_byte(crc_r, mem[idx_r]);
               idx_r <= idx_r + 8'h01;
               if (idx_r == `CRC_LAST) begin
                  ex_r <= EX_CHECK;
               end
            end
            EX_CHECK: begin
               ex_r   <= EX_IDLE;
               busy_r <= 1'b0;
               // Only the frame length and CRC are judged; key validity is never inferred.
               if (len_r == `FRAME_LEN &&
                   crc_r == {mem[`CRC_HI_IDX], mem[`CRC_LO_IDX]}) begin
                  cnt_r           <= cnt_r + 7'h01;
                  flash_page_wr_o <= (mem[1] == `SUB_FLASH_WR);
                  flash_final_o   <= (mem[1] == `SUB_FINAL);
               end else begin
                  err_r <= 1'b1;
               end
            end
            default: begin
               ex_r   <= EX_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // ========================================================
   // Mode control
   // After reset the device waits in bootloader mode; an access at the
   // bootloader address keeps it there, else it leaves if unlocked.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         boot_mode_o    <= 1'b1;
         held_r         <= 1'b0;
         wait_r         <= '0;
         jump_allowed_o <= 1'b0;
         int_o          <= 1'b0;
      end else begin
         jump_allowed_o <= lock_ok_w;
         int_o          <= boot_mode_o & ~busy_r;
         if (!boot_mode_o) begin
            if (spec_r == `SPEC_OP_BOOT) begin
               boot_mode_o <= 1'b1;
               held_r      <= 1'b1;
            end
         end else if (user_req_r) begin
            boot_mode_o <= 1'b0;
         end else if (st_r == S_ACK_A) begin
            held_r <= 1'b1;
         end else if (!held_r) begin
            if (wait_r == WW'(BOOT_WAIT - 1)) begin
               boot_mode_o <= ~lock_ok_w;
               held_r      <= 1'b1;
            end else begin
               wait_r <= wait_r + 1'b1;
            end
         end
      end
   end
endmodule : touch_boot_device

// ===== touch_boot_params.svh
// Constants shared by both ends of the touch bootloader command link.
`ifndef TOUCH_BOOT_PARAMS_SVH
`define TOUCH_BOOT_PARAMS_SVH
// ===========================================================
// Link addresses and opcodes
`define ADDR_NORMAL   7'h5c
`define ADDR_BOOT     7'h5d
`define SPEC_OP_IDX   8'h37
`define SPEC_OP_BOOT  8'h06
`define OP_INIT       8'h00
`define OP_FRAME      8'h04
`define OP_EE_PAGE    8'h05
`define OP_USER       8'h06
`define SUB_FLASH_WR  8'h01
`define SUB_FINAL     8'h02
// ===========================================================
// Frame and status layout
`define LOCK_OPEN     8'ha5
`define FRAME_LEN     8'd143
`define CRC_LAST      8'd140
`define CRC_HI_IDX    8'd141
`define CRC_LO_IDX    8'd142
`define CRC_POLY      16'h8005
`define CRC_ERR_BIT   7
`define BOOT_VERSION  8'h01
`define KEY_LABEL     8'h00
`define BOOT_WAIT     20000
// ===========================================================
// Timing
`define CLK_NS        50
`define LINK_NS       400
`define HOST_QTR      (`LINK_NS / (4 * `CLK_NS))
// ===========================================================
// Host command port map
`define HREG_CTRL     8'h00
`define HREG_LEN      8'h01
`define HREG_TXD      8'h02
`define HREG_RXD      8'h03
`define HREG_STAT     8'h04
`endif

// ===== touch_boot_pkg.sv
// Types shared by both ends of the touch bootloader command link.
package touch_boot_pkg;
   // =========================================================
   // State encodings
   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_ADDR  = 3'h1,
      S_ACK_A = 3'h3,
      S_WBYTE = 3'h2,
      S_ACK_W = 3'h6,
      S_RBYTE = 3'h7,
      S_RACK  = 3'h5
   } slave_state_t;
   typedef enum logic [1:0] {
      EX_IDLE  = 2'h0,
      EX_CRC   = 2'h1,
      EX_CHECK = 2'h3
   } exec_state_t;
   typedef enum logic [1:0] {
      H_IDLE  = 2'h0,
      H_START = 2'h1,
      H_BIT   = 2'h3,
      H_STOP  = 2'h2
   } host_state_t;
endpackage : touch_boot_pkg

// ===== i2c_link_if.sv
// Open-drain two-wire link joining the host and the touch device.
`timescale 1ns/1ps
interface i2c_link_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   wire  scl;
   wire  sda;
   // Wired-and with pull-ups: a line is low while any driver pulls it low.
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                 input scl, sda);
   modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : i2c_link_if

// ===== touch_boot_host.sv
// Host end: two-wire master driven from a small command port.
`timescale 1ns/1ps
`include "touch_boot_params.svh"
module touch_boot_host
   import touch_boot_pkg::*;
#(
   parameter int DEPTH = 256
) (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_i,
   i2c_link_if.host        link,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o
);
   localparam logic [7:0] QTR = 8'(`HOST_QTR);

   host_state_t st_r;
   logic [1:0]  sda_sync_r;
   logic        sda_s;
   logic [7:0]  div_r;
   logic        tick_w;
   logic [1:0]  ph_r;
   logic [3:0]  bit_r;
   logic [7:0]  byte_r;
   logic [7:0]  sh_r;
   logic [7:0]  slv_r;
   logic [7:0]  len_r;
   logic [7:0]  tx_wp_r;
   logic [7:0]  rx_rp_r;
   logic        nack_r;
   logic        scl_oe_r;
   logic        sda_oe_r;
   logic        wr_side_w;
   logic        go_w;
   logic [7:0]  tx_mem [0:DEPTH-1];
   logic [7:0]  rx_mem [0:DEPTH-1];

   assign sda_s     = sda_sync_r[1];
   assign tick_w    = (div_r == QTR - 8'h01);
   assign go_w      = wr_i && addr_i == `HREG_CTRL && st_r == H_IDLE;
   assign wr_side_w = (byte_r == 8'h00) || !slv_r[0];
   assign link.host_scl_o  = 1'b0;
   assign link.host_sda_o  = 1'b0;
   assign link.host_scl_oe = scl_oe_r;
   assign link.host_sda_oe = sda_oe_r;

   // ========================================================
   // Data line synchroniser and quarter-bit divider
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sda_sync_r <= 2'h3;
         div_r      <= 8'h00;
      end else begin
         sda_sync_r <= {sda_sync_r[0], link.sda};
         div_r      <= (tick_w || go_w) ? 8'h00 : div_r + 8'h01;
      end
   end

   // ========================================================
   // Command port: registers and buffers
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         len_r   <= 8'h00;
         tx_wp_r <= 8'h00;
         rx_rp_r <= 8'h00;
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= 8'h00;
         if (wr_i && addr_i == `HREG_LEN) begin
            len_r   <= wdata_i;
            tx_wp_r <= 8'h00;
            rx_rp_r <= 8'h00;
         end else if (wr_i && addr_i == `HREG_TXD) begin
            tx_wp_r <= tx_wp_r + 8'h01;
         end
         if (rd_i && addr_i == `HREG_RXD) begin
            rdata_o <= rx_mem[rx_rp_r];
            rx_rp_r <= rx_rp_r + 8'h01;
         end else if (rd_i && addr_i == `HREG_STAT) begin
            rdata_o <= {6'h00, nack_r, st_r != H_IDLE};
         end
      end
   end

   // Frame bytes queued by software and bytes read back from the device.
   always_ff @(posedge ref_clk_i) begin
      if (wr_i && addr_i == `HREG_TXD) begin
         tx_mem[tx_wp_r] <= wdata_i;
      end
      if (st_r == H_BIT && tick_w && ph_r == 2'h3 && bit_r == 4'h8 &&
          !wr_side_w) begin
         rx_mem[byte_r - 8'h01] <= sh_r;
      end
   end

   // ========================================================
   // Master sequencer: four quarter phases per bit
   // Phase 0 sets data, 1 raises clock, 3 samples and lowers clock.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r     <= H_IDLE;
         ph_r     <= 2'h0;
         bit_r    <= 4'h0;
         byte_r   <= 8'h00;
         sh_r     <= 8'h00;
         slv_r    <= 8'h00;
         nack_r   <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (go_w) begin
         st_r   <= H_START;
         ph_r   <= 2'h0;
         slv_r  <= wdata_i;
         nack_r <= 1'b0;
      end else if (tick_w) begin
         ph_r <= ph_r + 2'h1;
         case (st_r)
            H_START: begin
               case (ph_r)
                  2'h0: begin
                     scl_oe_r <= 1'b0;
                     sda_oe_r <= 1'b0;
                  end
                  2'h1: sda_oe_r <= 1'b1;
                  2'h2: scl_oe_r <= 1'b1;
                  default: begin
                     st_r   <= H_BIT;
                     bit_r  <= 4'h0;
                     byte_r <= 8'h00;
                     sh_r   <= slv_r;
                  end
               endcase
            end
            H_BIT: begin
               case (ph_r)
                  2'h0: begin
                     if (bit_r != 4'h8) begin
                        sda_oe_r <= wr_side_w & ~sh_r[7];
                     end else begin
                        sda_oe_r <= !wr_side_w && byte_r != len_r;
                     end
                  end
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: ;
                  default: begin
                     scl_oe_r <= 1'b1;
                     if (bit_r != 4'h8) begin
                        sh_r  <= {sh_r[6:0], sda_s};
                        bit_r <= bit_r + 4'h1;
                     end else if (wr_side_w && sda_s) begin
                        nack_r <= 1'b1;
                        st_r   <= H_STOP;
                     end else if (byte_r == len_r) begin
                        st_r <= H_STOP;
                     end else begin
                        byte_r <= byte_r + 8'h01;
                        bit_r  <= 4'h0;
                        sh_r   <= tx_mem[byte_r];
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (ph_r)
                  2'h0: sda_oe_r <= 1'b1;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b0;
                  default: st_r <= H_IDLE;
               endcase
            end
            default: ph_r <= 2'h0;
         endcase
      end
   end
endmodule : touch_boot_host

// ===== touch_boot_link_asserts.sv
// Checker for the two-wire link between host and device ends.
`timescale 1ns/1ps
module touch_boot_link_asserts (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic host_scl_o,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // Device data only moves while the clock line is low.
   property p_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
   a_hold: assert property (p_hold) else $error("sda moved in high");
   property p_low; $fell(scl) |-> !scl[*4] ##[0:4] scl; endproperty
   a_low: assert property (p_low) else $error("scl low time");
   property p_high; $rose(scl) |-> scl[*4]; endproperty
   a_high: assert property (p_high) else $error("scl high time");
   property p_st; scl && $past(scl) && $fell(sda) |-> host_sda_oe; endproperty
   a_st: assert property (p_st) else $error("start not by host");
   property p_ack; $rose(dev_sda_oe) |-> !scl; endproperty
   a_ack: assert property (p_ack) else $error("device drove in high");
   property p_idle; scl[*8] |-> !dev_sda_oe; endproperty
   a_idle: assert property (p_idle) else $error("device held idle bus");
   property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
   a_od: assert property (p_od) else $error("open drain level");
   property p_span; $rose(dev_sda_oe) |-> ##[1:80] !dev_sda_oe; endproperty
   a_span: assert property (p_span) else $error("device stuck low");
   c_start: cover property ($fell(sda) && scl);
   c_ack: cover property ($rose(dev_sda_oe));
   c_stop: cover property ($rose(sda) && scl);
endmodule : touch_boot_link_asserts

// ===== touch_bootloader_i2c_command_port_tb.sv
// Bench joining the host and device ends over the two-wire link.
`timescale 1ns/1ps
`include "touch_boot_params.svh"
`define CMP(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module touch_bootloader_i2c_command_port_tb;
   logic       ref_clk_i, reset_i, wr_i, rd_i, boot, jmp, intr, pg, fn, ee;
   logic       ee_fail;
   logic [1:0] chk;
   logic [7:0] addr_i, wdata_i, rdata_o, st, lock;
   logic [7:0] fr[143];
   logic [7:0] q[$];
   int         err_count, n_tests, cyc, n_pg, n_fn, n_ee, n_il;
   i2c_link_if lk();
   touch_boot_device #(.BOOT_WAIT(200)) i_touch_boot_device (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(lk),
      .flash_lock_i(lock), .ee_fail_i(ee_fail), .boot_mode_o(boot),
      .jump_allowed_o(jmp), .int_o(intr), .flash_page_wr_o(pg),
      .flash_final_o(fn), .ee_page_wr_o(ee));
   touch_boot_host i_touch_boot_host (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(lk), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   touch_boot_link_asserts i_touch_boot_link_asserts (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .host_scl_o(lk.host_scl_o),
      .host_sda_o(lk.host_sda_o), .host_sda_oe(lk.host_sda_oe),
      .dev_sda_o(lk.dev_sda_o), .dev_sda_oe(lk.dev_sda_oe),
      .scl(lk.scl), .sda(lk.sda));
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // One port cycle; chk 1 compares the answer, 2 captures it.
   task bus(input logic w, input logic [1:0] c, input logic [7:0] a, v);
      addr_i <= a;
      wdata_i <= v;
      if (w) wr_i <= 1'b1; else rd_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      chk <= c;
      @(posedge ref_clk_i);
      chk <= 2'd0;
   endtask : bus
   // Runs one transfer, retrying while the device refuses it.
   task xf(input logic [7:0] ctl, n);
      do begin
         bus(1'b1, 2'd0, `HREG_LEN, n);
         for (int i = 0; i < n && !ctl[0]; i++) bus(1'b1, 2'd0, `HREG_TXD, fr[i]);
         bus(1'b1, 2'd0, `HREG_CTRL, ctl);
         do bus(1'b0, 2'd2, `HREG_STAT, 8'h00); while (st[0] !== 1'b0);
      end while (st[1] !== 1'b0);
      for (int i = 0; i < n && ctl[0]; i++) bus(1'b0, 2'd1, `HREG_RXD, 8'h00);
   endtask : xf
   task stat(input logic [7:0] e);
      q.push_back(e);
      xf({`ADDR_BOOT, 1'b1}, 8'd1);
      $display("status test done");
   endtask : stat
   function automatic logic [15:0] crc(input int n);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 0; i < n; i++)
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[i][b]) ? `CRC_POLY : 16'h0000);
      return c;
   endfunction : crc
   // Compares each answer with the oldest noted expectation.
   always @(negedge ref_clk_i) begin
      n_pg += pg;
      n_fn += fn;
      n_ee += ee;
      n_il += boot & ~intr;
      if (chk == 2'd2) st = rdata_o;
      if (chk == 2'd1) begin
         `CMP("rdata", q[0], rdata_o)
         void'(q.pop_front());
      end
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end
   task results;
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      {reset_i, wr_i, rd_i, chk, addr_i, wdata_i} = {3'b100, 2'd0, 16'h0};
      {lock, ee_fail} = {`LOCK_OPEN, 1'b0};
      void'($urandom(86540));
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      `CMP("boot", 1'b1, boot)
      q = '{8'h00, `LOCK_OPEN, `BOOT_VERSION, `KEY_LABEL, 8'h00};
      xf({`ADDR_BOOT, 1'b1}, 8'd5);
      fr[0] = `OP_INIT;
      xf({`ADDR_BOOT, 1'b0}, 8'd1);
      foreach (fr[i]) fr[i] = 8'($urandom);
      fr[0] = `OP_FRAME;
      fr[1] = `SUB_FLASH_WR;
      {fr[141], fr[142]} = crc(141);
      n_il = 0;
      xf({`ADDR_BOOT, 1'b0}, `FRAME_LEN);
      stat(8'h01);
      `CMP("int_low", `CRC_LAST + 8'd2, n_il)
      `CMP("page_wr", 1, n_pg)
      // Second frame is a final check, sent first with a broken CRC.
      fr[1] = `SUB_FINAL;
      {fr[141], fr[142]} = crc(141) ^ 16'h0001;
      xf({`ADDR_BOOT, 1'b0}, `FRAME_LEN);
      stat(8'h81);
      fr[142] = fr[142] ^ 8'h01;
      xf({`ADDR_BOOT, 1'b0}, `FRAME_LEN);
      stat(8'h82);
      `CMP("final", 1, n_fn)
      fr[0] = `OP_INIT;
      xf({`ADDR_BOOT, 1'b0}, 8'd1);
      stat(8'h00);
      {fr[0], fr[1]} = {`OP_EE_PAGE, 8'h00};
      ee_fail <= 1'b1;
      xf({`ADDR_BOOT, 1'b0}, 8'd2);
      stat(8'h80);
      ee_fail <= 1'b0;
      `CMP("ee_wr", 1, n_ee)
      // A locked flash must refuse the return to normal mode.
      fr[0] = `OP_USER;
      lock <= 8'h00;
      xf({`ADDR_BOOT, 1'b0}, 8'd1);
      repeat (8) @(posedge ref_clk_i);
      `CMP("boot", 1'b1, boot)
      `CMP("jump", 1'b0, jmp)
      lock <= `LOCK_OPEN;
      xf({`ADDR_BOOT, 1'b0}, 8'd1);
      repeat (8) @(posedge ref_clk_i);
      `CMP("boot", 1'b0, boot)
      `CMP("jump", 1'b1, jmp)
      {fr[0], fr[1]} = {`SPEC_OP_IDX, `SPEC_OP_BOOT};
      xf({`ADDR_NORMAL, 1'b0}, 8'd2);
      repeat (8) @(posedge ref_clk_i);
      `CMP("boot", 1'b1, boot)
      $display("mode test done");
      results();
   end
endmodule : touch_bootloader_i2c_command_port_tb
